// >>> cms_pkg.sv
package cms_pkg;

  // ---------------------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] TEMP_OTG_EVENT_MASK_ADDR     = 8'h2B;
  localparam logic [7:0] PROTECTION_FAULT_MASK_A_ADDR = 8'h2C;
  localparam logic [7:0] PROTECTION_FAULT_MASK_B_ADDR = 8'h2D;

  // ---------------------------------------------------------------------------
  // reset values and writable bits
  // ---------------------------------------------------------------------------
  localparam logic [7:0] MASK_RESET_VALUE   = 8'h00;
  localparam logic [7:0] TEMP_OTG_WR_BITS   = 8'h1F;
  localparam logic [7:0] FAULT_A_WR_BITS    = 8'hFF;
  localparam logic [7:0] FAULT_B_WR_BITS    = 8'hF4;

  // ---------------------------------------------------------------------------
  // field positions, temperature/otg mask
  // ---------------------------------------------------------------------------
  localparam int BATTERY_LOW_FOR_OTG_MASK_BIT = 4;
  localparam int THERMISTOR_COLD_MASK_BIT     = 3;
  localparam int THERMISTOR_COOL_MASK_BIT     = 2;
  localparam int THERMISTOR_WARM_MASK_BIT     = 1;
  localparam int THERMISTOR_HOT_MASK_BIT      = 0;

  // ---------------------------------------------------------------------------
  // field positions, fault mask a
  // ---------------------------------------------------------------------------
  localparam int CHARGE_CURRENT_REGULATION_MASK_BIT  = 7;
  localparam int INPUT_BUS_OVERVOLTAGE_MASK_BIT      = 6;
  localparam int BATTERY_OVERVOLTAGE_MASK_BIT        = 5;
  localparam int INPUT_OVERCURRENT_MASK_BIT          = 4;
  localparam int BATTERY_OVERCURRENT_MASK_BIT        = 3;
  localparam int CONVERTER_OVERCURRENT_MASK_BIT      = 2;
  localparam int SECOND_ADAPTER_OVERVOLTAGE_MASK_BIT = 1;
  localparam int FIRST_ADAPTER_OVERVOLTAGE_MASK_BIT  = 0;

  // ---------------------------------------------------------------------------
  // field positions, fault mask b
  // ---------------------------------------------------------------------------
  localparam int SYSTEM_RAIL_SHORT_MASK_BIT          = 7;
  localparam int SYSTEM_RAIL_OVERVOLTAGE_MASK_BIT    = 6;
  localparam int SOURCE_OUTPUT_OVERVOLTAGE_MASK_BIT  = 5;
  localparam int SOURCE_OUTPUT_UNDERVOLTAGE_MASK_BIT = 4;
  localparam int DIE_THERMAL_SHUTDOWN_MASK_BIT       = 2;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 40;
  localparam int INT_PULSE_NS   = 1000;
  localparam int INT_PULSE_CYC  = (INT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INT_CNT_W      = 5;

endpackage

// >>> cms_mask_reg.sv
`timescale 1ns/100ps
module cms_mask_reg
  import cms_pkg::*;
#(
  parameter logic [7:0] WR_BITS   = 8'hFF,
  parameter bit         WD_CLEARS = 1'b0
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       reg_rst,
  input  wire logic       wd_expired,
  input  wire logic       wr_en,
  input  wire logic [7:0] wdata,
  output logic      [7:0] mask
);

  typedef struct packed {
    logic [7:0] mask;
  } cms_mreg_s;

  cms_mreg_s st_q;
  cms_mreg_s st_d;

  // register reset beats watchdog, watchdog beats a write in the same cycle
  always_comb begin
    st_d = st_q;
    if (reg_rst) begin
      st_d.mask = MASK_RESET_VALUE;
    end else if (WD_CLEARS && wd_expired) begin
      st_d.mask = MASK_RESET_VALUE;
    end else if (wr_en) begin
      st_d.mask = wdata & WR_BITS;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign mask = st_q.mask;

endmodule

// >>> cms_int_pulse.sv
`timescale 1ns/100ps
module cms_int_pulse
  import cms_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic trigger,
  output logic      int_n
);

  typedef struct packed {
    logic                 int_n;
    logic [INT_CNT_W-1:0] cnt;
  } cms_pulse_s;

  cms_pulse_s st_q;
  cms_pulse_s st_d;

  // a new event while low restarts the count, so bursts merge into one pulse
  always_comb begin
    st_d = st_q;
    if (trigger) begin
      st_d.int_n = 1'b0;
      st_d.cnt   = INT_CNT_W'(INT_PULSE_CYC - 1);
    end else if (st_q.cnt != '0) begin
      st_d.cnt = st_q.cnt - 1'b1;
    end else begin
      st_d.int_n = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '{int_n: 1'b1, cnt: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign int_n = st_q.int_n;

endmodule

// >>> cms_mask_bank.sv
`timescale 1ns/100ps
// Notes on behaviour
// - temp/otg bit 4 clear lets battery-too-low-for-otg event pulse the interrupt.
// - temp/otg bit 3 gates cold crossing; watchdog or register reset clears it.
// - temp/otg bit 2 gates cool crossing: 0 passes, 1 blocks.
// - temp/otg bit 1 gates warm crossing: 0 passes, 1 blocks.
// - temp/otg bit 0 gates hot crossing: 0 passes, 1 blocks.
// - fault a bit 7 gates charge regulation entry/exit; fault masks survive watchdog.
// - fault a bit 6 gates input bus over-voltage.
// - fault a bit 5 gates battery over-voltage.
// - fault a bit 4 gates input over-current.
// - fault a bit 3 gates battery over-current.
// - fault a bit 2 gates converter over-current.
// - fault a bit 1 gates second adapter over-voltage.
// - fault a bit 0 gates first adapter over-voltage.
// - fault b bit 7 gates system rail short.
// - fault b bit 6 gates system rail over-voltage.
// - fault b bit 5 gates source output over-voltage.
// - fault b bit 4 gates source output under-voltage.
// - fault b bit 2 gates die thermal shutdown; bits 1..0 read zero.
module cms_mask_bank
  import cms_pkg::*;
(
  input  wire logic       SYS_CLK,
  input  wire logic       SYS_RST,
  input  wire logic       REG_RST,
  input  wire logic       WATCHDOG_EXPIRED,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  input  wire logic [7:0] EVT_TEMP_OTG,
  input  wire logic [7:0] EVT_FAULT_A,
  input  wire logic [7:0] EVT_FAULT_B,
  output logic      [7:0] REG_RDATA,
  output logic            INT_N
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]           rdata;
    logic [INT_CNT_W-1:0] pulse_ref;
  } cms_top_s;

  cms_top_s   st_q;
  cms_top_s   st_d;
  logic [7:0] temp_mask;
  logic [7:0] fault_a_mask;
  logic [7:0] fault_b_mask;
  logic       wr_temp;
  logic       wr_fault_a;
  logic       wr_fault_b;
  logic [7:0] pass_temp;
  logic [7:0] pass_fault_a;
  logic [7:0] pass_fault_b;
  logic       trigger;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
    hit = (addr == reg_addr);
  endfunction

  function automatic logic [7:0] gate(input logic [7:0] evt, input logic [7:0] mask,
                                      input logic [7:0] keep);
    gate = evt & ~mask & keep;
  endfunction

  // ---------------------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------------------
  assign wr_temp    = REG_WR && hit(REG_ADDR, TEMP_OTG_EVENT_MASK_ADDR);
  assign wr_fault_a = REG_WR && hit(REG_ADDR, PROTECTION_FAULT_MASK_A_ADDR);
  assign wr_fault_b = REG_WR && hit(REG_ADDR, PROTECTION_FAULT_MASK_B_ADDR);

  // reserved bits are never stored, so they read back as zero
  cms_mask_reg #(
    .WR_BITS   (TEMP_OTG_WR_BITS),
    .WD_CLEARS (1'b1)
  ) u_temp_mask (
    .clk        (SYS_CLK),
    .rst        (SYS_RST),
    .reg_rst    (REG_RST),
    .wd_expired (WATCHDOG_EXPIRED),
    .wr_en      (wr_temp),
    .wdata      (REG_WDATA),
    .mask       (temp_mask)
  );

  cms_mask_reg #(
    .WR_BITS   (FAULT_A_WR_BITS),
    .WD_CLEARS (1'b0)
  ) u_fault_a_mask (
    .clk        (SYS_CLK),
    .rst        (SYS_RST),
    .reg_rst    (REG_RST),
    .wd_expired (WATCHDOG_EXPIRED),
    .wr_en      (wr_fault_a),
    .wdata      (REG_WDATA),
    .mask       (fault_a_mask)
  );

  cms_mask_reg #(
    .WR_BITS   (FAULT_B_WR_BITS),
    .WD_CLEARS (1'b0)
  ) u_fault_b_mask (
    .clk        (SYS_CLK),
    .rst        (SYS_RST),
    .reg_rst    (REG_RST),
    .wd_expired (WATCHDOG_EXPIRED),
    .wr_en      (wr_fault_b),
    .wdata      (REG_WDATA),
    .mask       (fault_b_mask)
  );

  // ---------------------------------------------------------------------------
  // event gating
  // ---------------------------------------------------------------------------
  // events on reserved positions are dropped by the writable-bit masks
  assign pass_temp    = gate(EVT_TEMP_OTG,
                             temp_mask,
                             TEMP_OTG_WR_BITS);
  assign pass_fault_a = gate(EVT_FAULT_A,
                             fault_a_mask,
                             FAULT_A_WR_BITS);
  assign pass_fault_b = gate(EVT_FAULT_B,
                             fault_b_mask,
                             FAULT_B_WR_BITS);
  assign trigger      = (|pass_temp) || (|pass_fault_a) || (|pass_fault_b);

  cms_int_pulse u_int_pulse (
    .clk     (SYS_CLK),
    .rst     (SYS_RST),
    .trigger (trigger),
    .int_n   (INT_N)
  );

  // ---------------------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------------------
  // read data holds until the next read; unmapped offsets answer zero
  always_comb begin
    st_d = st_q;
    if (REG_RD) begin
      if (hit(REG_ADDR, TEMP_OTG_EVENT_MASK_ADDR)) begin
        st_d.rdata = temp_mask;
      end else if (hit(REG_ADDR, PROTECTION_FAULT_MASK_A_ADDR)) begin
        st_d.rdata = fault_a_mask;
      end else if (hit(REG_ADDR, PROTECTION_FAULT_MASK_B_ADDR)) begin
        st_d.rdata = fault_b_mask;
      end else begin
        st_d.rdata = 8'h00;
      end
    end
    // checker reference only: low cycles still owed since the last qualifying event
    if (trigger) begin
      st_d.pulse_ref = INT_CNT_W'(INT_PULSE_CYC);
    end else if (st_q.pulse_ref != '0) begin
      st_d.pulse_ref = st_q.pulse_ref - 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign REG_RDATA = st_q.rdata;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  property p_otg_low_pass;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      EVT_TEMP_OTG[BATTERY_LOW_FOR_OTG_MASK_BIT] && !temp_mask[BATTERY_LOW_FOR_OTG_MASK_BIT]
      |=> !INT_N;
  endproperty
  a_otg_low_pass: assert property (p_otg_low_pass) else $error("otg low event lost");

  property p_wd_clears_temp;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      WATCHDOG_EXPIRED |=> temp_mask == 8'h00;
  endproperty
  a_wd_clears_temp: assert property (p_wd_clears_temp) else $error("wd left temp mask");

  property p_temp_pass;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (EVT_TEMP_OTG[3:0] & ~temp_mask[3:0]) != 4'h0 |=> !INT_N ##1 !INT_N;
  endproperty
  a_temp_pass: assert property (p_temp_pass) else $error("thermistor event lost");

  property p_wd_keeps_fault;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      WATCHDOG_EXPIRED && !REG_RST && !REG_WR
      |=> fault_a_mask == $past(fault_a_mask) && fault_b_mask == $past(fault_b_mask);
  endproperty
  a_wd_keeps_fault: assert property (p_wd_keeps_fault) else $error("wd hit fault mask");

  property p_reg_rst_clears;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      REG_RST |=> (temp_mask | fault_a_mask | fault_b_mask) == 8'h00;
  endproperty
  a_reg_rst_clears: assert property (p_reg_rst_clears) else $error("reset left a mask");

  property p_fault_a_pass;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (EVT_FAULT_A & ~fault_a_mask) != 8'h00 |=> !INT_N;
  endproperty
  a_fault_a_pass: assert property (p_fault_a_pass) else $error("fault a event lost");

  property p_fault_b_pass;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (EVT_FAULT_B & ~fault_b_mask & FAULT_B_WR_BITS) != 8'h00 |=> !INT_N;
  endproperty
  a_fault_b_pass: assert property (p_fault_b_pass) else $error("fault b event lost");

  property p_reserved_zero;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      temp_mask[7:5] == 3'h0 && fault_b_mask[3] == 1'b0 && fault_b_mask[1:0] == 2'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_quiet_stays_high;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      INT_N && !trigger |=> INT_N;
  endproperty
  a_quiet_stays_high: assert property (p_quiet_stays_high) else $error("spurious pulse");

  property p_pulse_width;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      $fell(INT_N) |-> !INT_N [*8];
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("pulse too short");

  property p_pulse_ends;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      st_q.pulse_ref == '0 |-> INT_N;
  endproperty
  a_pulse_ends: assert property (p_pulse_ends) else $error("pulse never ends");

  property p_pulse_holds;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      st_q.pulse_ref != '0 |-> !INT_N;
  endproperty
  a_pulse_holds: assert property (p_pulse_holds) else $error("pulse cut short");

  property p_cold_pass;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      EVT_TEMP_OTG[THERMISTOR_COLD_MASK_BIT] && !temp_mask[THERMISTOR_COLD_MASK_BIT]
      |=> !INT_N;
  endproperty
  a_cold_pass: assert property (p_cold_pass) else $error("cold event lost");

  property p_warm_pass;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      EVT_TEMP_OTG[THERMISTOR_WARM_MASK_BIT] && !temp_mask[THERMISTOR_WARM_MASK_BIT]
      |=> !INT_N;
  endproperty
  a_warm_pass: assert property (p_warm_pass) else $error("warm event lost");

  property p_hot_pass;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      EVT_TEMP_OTG[THERMISTOR_HOT_MASK_BIT] && !temp_mask[THERMISTOR_HOT_MASK_BIT]
      |=> !INT_N;
  endproperty
  a_hot_pass: assert property (p_hot_pass) else $error("hot event lost");

  property p_batt_ov_pass;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      EVT_FAULT_A[BATTERY_OVERVOLTAGE_MASK_BIT] && !fault_a_mask[BATTERY_OVERVOLTAGE_MASK_BIT]
      |=> !INT_N;
  endproperty
  a_batt_ov_pass: assert property (p_batt_ov_pass) else $error("battery ov lost");

  property p_source_ov_pass;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      EVT_FAULT_B[SOURCE_OUTPUT_OVERVOLTAGE_MASK_BIT]
      && !fault_b_mask[SOURCE_OUTPUT_OVERVOLTAGE_MASK_BIT] |=> !INT_N;
  endproperty
  a_source_ov_pass: assert property (p_source_ov_pass) else $error("source ov lost");

  property p_source_uv_pass;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      EVT_FAULT_B[SOURCE_OUTPUT_UNDERVOLTAGE_MASK_BIT]
      && !fault_b_mask[SOURCE_OUTPUT_UNDERVOLTAGE_MASK_BIT] |=> !INT_N;
  endproperty
  a_source_uv_pass: assert property (p_source_uv_pass) else $error("source uv lost");

  property p_cool_blocked;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      INT_N && temp_mask[THERMISTOR_COOL_MASK_BIT]
      && EVT_FAULT_A == 8'h00 && EVT_FAULT_B == 8'h00
      && EVT_TEMP_OTG == (8'h01 << THERMISTOR_COOL_MASK_BIT) |=> INT_N;
  endproperty
  a_cool_blocked: assert property (p_cool_blocked) else $error("masked cool event passed");

  property p_rdata_hold;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      !REG_RD |=> $stable(REG_RDATA);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  property p_temp_write;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      REG_WR && REG_ADDR == TEMP_OTG_EVENT_MASK_ADDR && !REG_RST && !WATCHDOG_EXPIRED
      |=> temp_mask == ($past(REG_WDATA) & TEMP_OTG_WR_BITS);
  endproperty
  a_temp_write: assert property (p_temp_write) else $error("temp mask write wrong");

  property p_readback_b;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      REG_RD && REG_ADDR == PROTECTION_FAULT_MASK_B_ADDR |=> REG_RDATA == $past(fault_b_mask);
  endproperty
  a_readback_b: assert property (p_readback_b) else $error("fault b readback wrong");

endmodule

// >>> cms_host.sv
`timescale 1ns/100ps
module cms_host (
  input  wire logic       SYS_CLK,
  input  wire logic [7:0] REG_RDATA,
  output logic      [7:0] REG_ADDR,
  output logic      [7:0] REG_WDATA,
  output logic            REG_WR,
  output logic            REG_RD
);
  // ---------------------------------------------------------------------------
  // host side of the register strobe port
  // ---------------------------------------------------------------------------
  initial begin
    REG_ADDR  = 8'hD4;
    REG_WDATA = 8'hA5;
    REG_WR    = 1'b0;
    REG_RD    = 1'b0;
  end

  // released lines carry the inverse, so a stale value never passes for a live one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    REG_ADDR  <= a;
    REG_WDATA <= d;
    REG_WR    <= 1'b1;
    @(posedge SYS_CLK);
    REG_WR    <= 1'b0;
    REG_ADDR  <= ~a;
    REG_WDATA <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge SYS_CLK);
    REG_ADDR <= a;
    REG_RD   <= 1'b1;
    @(posedge SYS_CLK);
    REG_RD   <= 1'b0;
    REG_ADDR <= ~a;
    #1;
    d = REG_RDATA;
  endtask
endmodule

// >>> charger_interrupt_mask_bank_bench.sv
`timescale 1ns/100ps
module charger_interrupt_mask_bank_bench
  import cms_pkg::*;
;
  logic       sys_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       reg_rst = 1'b0;
  logic       wd_exp  = 1'b0;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] evt [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0] reg_rdata;
  logic       int_n;
  int         errors = 0;
  int         samples_checked = 0;
  int         seed = 51267;
  logic [7:0] wbits [3] = '{TEMP_OTG_WR_BITS, FAULT_A_WR_BITS, FAULT_B_WR_BITS};
  logic [7:0] model [3] = '{8'h00, 8'h00, 8'h00};

  always #20 sys_clk = ~sys_clk;

  cms_mask_bank dut_u (
    .SYS_CLK          (sys_clk),
    .SYS_RST          (sys_rst),
    .REG_RST          (reg_rst),
    .WATCHDOG_EXPIRED (wd_exp),
    .REG_ADDR         (reg_addr),
    .REG_WDATA        (reg_wdata),
    .REG_WR           (reg_wr),
    .REG_RD           (reg_rd),
    .EVT_TEMP_OTG     (evt[0]),
    .EVT_FAULT_A      (evt[1]),
    .EVT_FAULT_B      (evt[2]),
    .REG_RDATA        (reg_rdata),
    .INT_N            (int_n)
  );

  cms_host host_u (
    .SYS_CLK   (sys_clk),
    .REG_RDATA (reg_rdata),
    .REG_ADDR  (reg_addr),
    .REG_WDATA (reg_wdata),
    .REG_WR    (reg_wr),
    .REG_RD    (reg_rd)
  );

  // ---------------------------------------------------------------------------
  // compare and close
  // ---------------------------------------------------------------------------
  task automatic chk_data(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_pulse(input string nm, input int e, input int g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic close_out;
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // helpers working against the model
  // ---------------------------------------------------------------------------
  task automatic put(input int r, input logic [7:0] d);
    host_u.wr(TEMP_OTG_EVENT_MASK_ADDR + 8'(r), d);
    model[r] = d & wbits[r];
  endtask

  task automatic check_all(input string nm);
    logic [7:0] d;
    for (int r = 0; r < 3; r++) begin
      host_u.rd(TEMP_OTG_EVENT_MASK_ADDR + 8'(r), d);
      chk_data(nm, model[r], d);
    end
  endtask

  task automatic fire(input int r, input logic [7:0] v, input int e);
    int n;
    n = 0;
    @(posedge sys_clk);
    evt[r] <= v;
    @(posedge sys_clk);
    evt[r] <= 8'h00;
    #1;
    while (int_n === 1'b0 && n < 40) begin
      n++;
      @(posedge sys_clk);
      #1;
    end
    chk_pulse("int_n low cycles", e, n);
    chk_data("int_n idle", 8'h01, {7'h00, int_n});
    repeat (2) @(posedge sys_clk);
  endtask

  // ---------------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------------
  initial begin
    logic [7:0] d;
    logic [7:0] a;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    check_all("reset value");
    host_u.rd(8'h2E, d);
    chk_data("unmapped read", 8'h00, d);
    $display("test reset done");

    for (int i = 0; i < 16; i++) begin
      a = 8'h2A + 8'($unsigned($random(seed)) % 4);
      d = 8'($random(seed));
      host_u.wr(a, d);
      if (a != 8'h2A) model[a - 8'h2B] = d & wbits[a - 8'h2B];
      host_u.rd(a, d);
      chk_data("readback", (a == 8'h2A) ? 8'h00 : model[a - 8'h2B], d);
    end
    $display("test readback done");

    for (int r = 0; r < 3; r++) put(r, 8'hFF);
    @(posedge sys_clk);
    wd_exp <= 1'b1;
    @(posedge sys_clk);
    wd_exp <= 1'b0;
    model[0] = 8'h00;
    check_all("watchdog clear");
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk_data("rdata in reset", 8'h00, reg_rdata);
    sys_rst <= 1'b0;
    model = '{8'h00, 8'h00, 8'h00};
    check_all("system reset");
    for (int r = 0; r < 3; r++) put(r, 8'hFF);
    @(posedge sys_clk);
    reg_rst <= 1'b1;
    @(posedge sys_clk);
    reg_rst <= 1'b0;
    model = '{8'h00, 8'h00, 8'h00};
    check_all("register reset");
    $display("test clears done");

    // every event position, once unmasked and once masked; reserved positions expect no pulse
    for (int r = 0; r < 3; r++) begin
      for (int b = 0; b < 8; b++) begin
        put(r, ~(8'h01 << b));
        fire(r, 8'h01 << b, wbits[r][b] ? INT_PULSE_CYC : 0);
        put(r, 8'hFF);
        fire(r, 8'h01 << b, 0);
      end
    end
    put(1, 8'h00);
    fire(1, 8'h81, INT_PULSE_CYC);
    $display("test interrupt gating done");
    close_out();
  end

  initial begin
    #400000;
    errors++;
    close_out();
  end
endmodule
